// [bench/byte_alu_core_test.sv]
// Self-checking bench for the byte ALU datapath.
// Assumes the bench drives every port itself and keeps a reference model.
`timescale 1ns/100ps
`default_nettype none
module byte_alu_core_test;
  import byte_alu_pkg::*;
  // ---------------------------------------------------------------
  // Signals and reference state
  // ---------------------------------------------------------------
  logic core_clk, reset, op_valid, op_dest_sel, op_ptr_sel, host_wr, host_rd;
  op_t op_code;
  logic [DATA_W-1:0] op_literal, host_wdata, host_rdata, acc_r;
  logic [FILE_AW-1:0] op_file_addr, host_addr;
  logic [BIT_SEL_W-1:0] op_bit_sel;
  logic busy_r, done_r, carry_r, nibble_overflow_bit_r, zero_r;
  logic [PTR_W-1:0] ptr0_r, ptr1_r;
  logic [DATA_W-1:0] m_acc;
  logic [DATA_W-1:0] m_mem [FILE_DEPTH];
  logic m_c, m_dc, m_z;
  logic [PTR_W-1:0] m_ptr [2];
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;

  byte_alu_core byte_alu_core_inst (.core_clk(core_clk), .reset(reset), .op_valid(op_valid),
    .op_code(op_code), .op_literal(op_literal), .op_file_addr(op_file_addr),
    .op_dest_sel(op_dest_sel), .op_bit_sel(op_bit_sel), .op_ptr_sel(op_ptr_sel),
    .busy_r(busy_r), .done_r(done_r), .acc_r(acc_r), .carry_r(carry_r),
    .nibble_overflow_bit_r(nibble_overflow_bit_r), .zero_r(zero_r), .ptr0_r(ptr0_r),
    .ptr1_r(ptr1_r), .host_addr(host_addr), .host_wdata(host_wdata), .host_wr(host_wr),
    .host_rd(host_rd), .host_rdata(host_rdata));

  // ---------------------------------------------------------------
  // Clock and timeout
  // ---------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------
  task automatic check_val(input logic [PTR_W-1:0] got, input logic [PTR_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic check_lat(input int got, input int exp);
    num_checks++;
    if (got != exp) begin
      fails++;
      $display("unexpected latency at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic host_write(input logic [FILE_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge core_clk);
    host_wr <= 1'b0;
    m_mem[a] = d;
  endtask

  task automatic host_read(input logic [FILE_AW-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge core_clk);
    host_rd <= 1'b0;
    #1;
    d = host_rdata;
  endtask

  // ---------------------------------------------------------------
  // Reference model
  // ---------------------------------------------------------------
  function automatic logic [FILE_AW-1:0] eff_addr(input logic [FILE_AW-1:0] a);
    if (a == INDIRECT0_ADDR) return m_ptr[0][FILE_AW-1:0];
    if (a == INDIRECT1_ADDR) return m_ptr[1][FILE_AW-1:0];
    return a;
  endfunction

  function automatic logic uses_file(input op_t o);
    return o inside {and_register_op, add_register_op, arith_shift_right_op, add_with_carry_op, clear_bit_op};
  endfunction

  function automatic logic model_op(input op_t o, input logic [7:0] lit, input logic [6:0] wa,
                                    input logic d, input logic [2:0] b, input logic ps);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] x, r;
    logic cin;
    x = (o inside {and_literal_op, add_literal_op}) ? lit : m_mem[wa];
    cin = (o == add_with_carry_op) ? m_c : 1'b0;
    s = m_acc + x + cin;
    n = m_acc[3:0] + x[3:0] + cin;
    r = s[7:0];
    if (o == pointer_add_literal) begin
      m_ptr[ps] = m_ptr[ps] + {{10{lit[5]}}, lit[5:0]};
      return 1'b0;
    end
    if (o == clear_bit_op) begin
      m_mem[wa] = x & ~(8'h01 << b);
      return 1'b1;
    end
    if (o inside {and_literal_op, and_register_op}) r = m_acc & x;
    if (o == arith_shift_right_op) r = {x[7], x[7:1]};
    if (o inside {add_literal_op, add_register_op, add_with_carry_op}) begin
      m_c = s[8];
      m_dc = n[4];
    end
    if (o == arith_shift_right_op) m_c = x[0];
    m_z = (r == 8'h00);
    if (uses_file(o) && d) begin
      m_mem[wa] = r;
      return 1'b1;
    end
    m_acc = r;
    return 1'b0;
  endfunction

  // ---------------------------------------------------------------
  // Issue one operation and compare
  // ---------------------------------------------------------------
  task automatic do_op(input op_t o, input logic [7:0] lit, input logic [6:0] a, input logic d,
                       input logic [2:0] b, input logic ps);
    logic [6:0] wa;
    logic [7:0] got;
    logic wrote;
    int n;
    int lat;
    lat = (uses_file(o) && a < 7'h02 && m_ptr[a[0]][PTR_MSB_POS]) ? 3 : 2;
    wa = eff_addr(a);
    wrote = model_op(o, lit, wa, d, b, ps);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_code <= o;
    op_literal <= lit;
    op_file_addr <= a;
    op_dest_sel <= d;
    op_bit_sel <= b;
    op_ptr_sel <= ps;
    n = 0;
    do begin
      @(posedge core_clk);
      if (n == 0) op_valid <= 1'b0;
      n++;
      #1;
      if (n == 1) check_val(busy_r, 1'b1);
    end while (done_r !== 1'b1 && n < 10);
    check_lat(n, lat);
    check_val(busy_r, 1'b0);
    check_val(acc_r, m_acc);
    check_val(carry_r, m_c);
    check_val(nibble_overflow_bit_r, m_dc);
    check_val(zero_r, m_z);
    check_val(ptr0_r, m_ptr[0]);
    check_val(ptr1_r, m_ptr[1]);
    if (wrote) begin
      host_read(wa, got);
      check_val(got, m_mem[wa]);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = pointer_add_literal;
    op_literal = 8'h00;
    op_file_addr = 7'h00;
    op_dest_sel = 1'b0;
    op_bit_sel = 3'h0;
    op_ptr_sel = 1'b0;
    host_addr = 7'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
    void'($urandom(61124));
    m_acc = ACC_RST;
    {m_c, m_dc, m_z} = 3'h0;
    m_ptr[0] = PTR_RST;
    m_ptr[1] = PTR_RST;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    #1;
    check_val(acc_r, m_acc);
    check_val({busy_r, done_r, carry_r, nibble_overflow_bit_r, zero_r}, 16'h0000);
    check_val(ptr0_r | ptr1_r, PTR_RST);
    $display("test reset done");

    for (int i = 2; i < FILE_DEPTH; i++) host_write(i[6:0], 8'($urandom));
    host_write(7'h3e, 8'h81);
    host_write(7'h60, 8'h0f);
    host_write(7'h05, 8'h80);
    do_op(pointer_add_literal, 8'h1f, 7'h10, 1'b0, 3'h0, 1'b0);
    do_op(pointer_add_literal, 8'h1f, 7'h10, 1'b0, 3'h0, 1'b0);
    do_op(pointer_add_literal, 8'h20, 7'h10, 1'b0, 3'h0, 1'b1);
    do_op(add_literal_op, 8'hff, 7'h10, 1'b0, 3'h0, 1'b0);
    do_op(add_literal_op, 8'h01, 7'h10, 1'b0, 3'h0, 1'b0);
    do_op(and_literal_op, 8'h00, 7'h10, 1'b0, 3'h0, 1'b0);
    do_op(arith_shift_right_op, 8'h00, 7'h00, 1'b1, 3'h0, 1'b0);
    do_op(add_with_carry_op, 8'h00, 7'h01, 1'b0, 3'h0, 1'b0);
    do_op(add_with_carry_op, 8'h00, 7'h05, 1'b1, 3'h0, 1'b0);
    do_op(and_register_op, 8'h00, 7'h05, 1'b1, 3'h0, 1'b0);
    do_op(and_register_op, 8'h00, 7'h01, 1'b0, 3'h0, 1'b0);
    do_op(add_register_op, 8'h00, 7'h05, 1'b0, 3'h0, 1'b0);
    do_op(add_register_op, 8'h00, 7'h01, 1'b1, 3'h0, 1'b0);
    do_op(clear_bit_op, 8'h00, 7'h01, 1'b0, 3'h4, 1'b0);
    do_op(clear_bit_op, 8'h00, 7'h00, 1'b1, 3'h7, 1'b0);
    do_op(pointer_add_literal, 8'h1f, 7'h10, 1'b0, 3'h0, 1'b1);
    do_op(pointer_add_literal, 8'h01, 7'h10, 1'b0, 3'h0, 1'b1);
    do_op(pointer_add_literal, 8'h3f, 7'h10, 1'b0, 3'h0, 1'b1);
    $display("test corners done");

    for (int i = 0; i < 300; i++) begin
      do_op(op_t'($urandom_range(0, 7)), 8'($urandom), 7'($urandom_range(2, 127)), 1'($urandom),
            3'($urandom), 1'($urandom));
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [rtl/byte_alu_core.sv]
// Execution datapath for a subset of byte and pointer instructions.
// Assumes the issuer pulses op_valid for one cycle while idle; one clock, sync reset.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module byte_alu_core
  import byte_alu_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Instruction issue
  input wire logic op_valid,
  input wire op_t op_code,
  input wire logic [DATA_W-1:0] op_literal,
  input wire logic [FILE_AW-1:0] op_file_addr,
  input wire logic op_dest_sel,
  input wire logic [BIT_SEL_W-1:0] op_bit_sel,
  input wire logic op_ptr_sel,
  output logic busy_r,
  output logic done_r,
  // Architectural state
  output logic [DATA_W-1:0] acc_r,
  output logic carry_r,
  output logic nibble_overflow_bit_r,
  output logic zero_r,
  output logic [PTR_W-1:0] ptr0_r,
  output logic [PTR_W-1:0] ptr1_r,
  // Host access to data memory
  input wire logic [FILE_AW-1:0] host_addr,
  input wire logic [DATA_W-1:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [DATA_W-1:0] host_rdata
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  state_t state_r;
  state_t state_nxt;
  op_t op_r;
  logic [DATA_W-1:0] lit_r;
  logic [FILE_AW-1:0] eff_addr_r;
  logic dest_r;
  logic [BIT_SEL_W-1:0] bit_r;
  logic ptr_sel_r;
  logic accept;
  logic uses_file;
  logic is_indirect;
  logic needs_extra;
  logic [FILE_AW-1:0] eff_addr;
  logic [DATA_W-1:0] file_q;
  logic [DATA_W-1:0] operand_b;
  logic carry_in;
  logic [DATA_W:0] sum9;
  logic [NIB_W:0] nib_sum;
  logic [DATA_W-1:0] result;
  logic upd_c;
  logic upd_dc;
  logic upd_z;
  logic new_c;
  logic write_file;
  logic write_acc;
  logic exec;
  logic [PTR_W-1:0] ptr_sum;
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (reset);

  assign accept = op_valid && (state_r == ST_IDLE);
  assign exec = (state_r == ST_EXEC);
  assign uses_file = !(op_code inside {pointer_add_literal, and_literal_op, add_literal_op});

  // ---------------------------------------------------------------
  // Indirect address resolution
  // ---------------------------------------------------------------
  always_comb begin
    is_indirect = 1'b0;
    needs_extra = 1'b0;
    eff_addr = op_file_addr;
    if (op_file_addr == INDIRECT0_ADDR) begin
      is_indirect = 1'b1;
      eff_addr = ptr0_r[FILE_AW-1:0];
      needs_extra = ptr0_r[PTR_MSB_POS];
    end else if (op_file_addr == INDIRECT1_ADDR) begin
      is_indirect = 1'b1;
      eff_addr = ptr1_r[FILE_AW-1:0];
      needs_extra = ptr1_r[PTR_MSB_POS];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          if (uses_file && is_indirect && needs_extra) begin
            state_nxt = ST_EXTRA;
          end else begin
            state_nxt = ST_EXEC;
          end
        end
      end
      ST_EXTRA: state_nxt = ST_EXEC;
      ST_EXEC: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      busy_r <= (state_nxt != ST_IDLE);
      done_r <= exec;
    end
  end

  // ---------------------------------------------------------------
  // Operand capture
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      op_r <= pointer_add_literal;
      lit_r <= BYTE_ZERO;
      eff_addr_r <= INDIRECT0_ADDR;
      dest_r <= DEST_ACC;
      bit_r <= '0;
      ptr_sel_r <= 1'b0;
    end else if (accept) begin
      op_r <= op_code;
      lit_r <= op_literal;
      eff_addr_r <= eff_addr;
      dest_r <= op_dest_sel;
      bit_r <= op_bit_sel;
      ptr_sel_r <= op_ptr_sel;
    end
  end

  // ---------------------------------------------------------------
  // Data memory
  // ---------------------------------------------------------------
  file_ram file_ram_inst (
    .core_clk(core_clk),
    .a_addr(host_addr),
    .a_wdata(host_wdata),
    .a_wr(host_wr),
    .a_rd(host_rd),
    .a_rdata(host_rdata),
    .b_addr(exec ? eff_addr_r : eff_addr),
    .b_wdata(result),
    .b_wr(write_file),
    .b_rd(accept && uses_file),
    .b_rdata(file_q)
  );

  // ---------------------------------------------------------------
  // Arithmetic and logic
  // ---------------------------------------------------------------
  always_comb begin
    case (op_r)
      and_literal_op, add_literal_op: operand_b = lit_r;
      default: operand_b = file_q;
    endcase
  end

  assign carry_in = (op_r == add_with_carry_op) ? carry_r : 1'b0;
  // Carry out of bits 7 and 3
  assign sum9 = {1'b0, acc_r} + {1'b0, operand_b} + {{DATA_W{1'b0}}, carry_in};
  assign nib_sum = {1'b0, acc_r[NIB_W-1:0]} + {1'b0, operand_b[NIB_W-1:0]} + {{NIB_W{1'b0}}, carry_in};

  always_comb begin
    result = BYTE_ZERO;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    upd_z = 1'b0;
    new_c = sum9[DATA_W];
    case (op_r)
      and_literal_op: begin
        result = acc_r & lit_r;
        upd_z = 1'b1;
      end
      add_literal_op, add_register_op, add_with_carry_op: begin
        result = sum9[DATA_W-1:0];
        upd_c = 1'b1;
        upd_dc = 1'b1;
        upd_z = 1'b1;
      end
      and_register_op: begin
        result = acc_r & file_q;
        upd_z = 1'b1;
      end
      arith_shift_right_op: begin
        result = {file_q[MSB_POS], file_q[MSB_POS:1]};
        new_c = file_q[0];
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      clear_bit_op: begin
        result = file_q & ~(8'h01 << bit_r);
      end
      default: result = BYTE_ZERO;
    endcase
  end

  // ---------------------------------------------------------------
  // Destination select
  // ---------------------------------------------------------------
  always_comb begin
    write_acc = 1'b0;
    write_file = 1'b0;
    if (exec) begin
      case (op_r)
        and_literal_op, add_literal_op: write_acc = 1'b1;
        clear_bit_op: write_file = 1'b1;
        pointer_add_literal: write_acc = 1'b0;
        default: begin
          write_acc = (dest_r == DEST_ACC);
          write_file = (dest_r == DEST_FILE);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      acc_r <= ACC_RST;
    end else if (write_acc) begin
      acc_r <= result;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      carry_r <= 1'b0;
      nibble_overflow_bit_r <= 1'b0;
      zero_r <= 1'b0;
    end else if (exec) begin
      if (upd_c) begin
        carry_r <= new_c;
      end
      if (upd_dc) begin
        nibble_overflow_bit_r <= nib_sum[NIB_W];
      end
      if (upd_z) begin
        zero_r <= (result == BYTE_ZERO);
      end
    end
  end

  // ---------------------------------------------------------------
  // Indirect pointer pairs
  // ---------------------------------------------------------------
  // Sign-extended, wrapping sum
  assign ptr_sum = (ptr_sel_r ? ptr1_r : ptr0_r)
    + {{(PTR_W-PTR_LIT_W){lit_r[PTR_LIT_W-1]}}, lit_r[PTR_LIT_W-1:0]};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ptr0_r <= PTR_RST;
      ptr1_r <= PTR_RST;
    end else if (exec && (op_r == pointer_add_literal)) begin
      if (ptr_sel_r) begin
        ptr1_r <= ptr_sum;
      end else begin
        ptr0_r <= ptr_sum;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] chk_wdata;
  logic chk_wr;
  always_ff @(posedge core_clk) begin
    chk_wdata <= result;
    chk_wr <= write_file;
  end

  sequence s_issue_lit(op_t o);
    accept && op_code == o;
  endsequence
  property p_ptr_add;
    s_issue_lit(pointer_add_literal) |=> ##1 done_r && $stable(carry_r) && $stable(zero_r)
      && $stable(nibble_overflow_bit_r);
  endproperty
  a_ptr_add: assert property (p_ptr_add) else $error("pointer add changed a flag");
  property p_ptr_wrap;
    accept && op_code == pointer_add_literal && !op_ptr_sel |=>
      ##1 ptr0_r == $past(ptr0_r, 2) + {{10{$past(op_literal[5], 2)}}, $past(op_literal[5:0], 2)};
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer sum not modulo 16 bits");
  property p_and_lit;
    s_issue_lit(and_literal_op) |=> ##1 acc_r == ($past(acc_r, 2) & $past(op_literal, 2))
      && $stable(carry_r);
  endproperty
  a_and_lit: assert property (p_and_lit) else $error("literal AND wrong");
  property p_add_lit;
    s_issue_lit(add_literal_op) |=> ##1 {carry_r, acc_r} == {1'b0, $past(acc_r, 2)} + {1'b0, $past(op_literal, 2)}
      && zero_r == (acc_r == BYTE_ZERO);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("literal add wrong");
  property p_and_reg_dest;
    exec && op_r == and_register_op && dest_r == DEST_FILE |-> write_file && !write_acc ##1 $stable(carry_r);
  endproperty
  a_and_reg_dest: assert property (p_and_reg_dest) else $error("register AND routed wrong");
  property p_shift;
    exec && op_r == arith_shift_right_op |=> carry_r == $past(file_q[0])
      && $stable(nibble_overflow_bit_r);
  endproperty
  a_shift: assert property (p_shift) else $error("shift carry wrong");
  property p_clear_bit;
    exec && op_r == clear_bit_op |=> chk_wr && chk_wdata[$past(bit_r)] == 1'b0 && $stable(zero_r);
  endproperty
  a_clear_bit: assert property (p_clear_bit) else $error("bit clear wrong");
  sequence s_slow_issue;
    accept && uses_file && is_indirect && needs_extra;
  endsequence
  property p_extra;
    s_slow_issue |=> !done_r [*2] ##1 done_r;
  endproperty
  a_extra: assert property (p_extra) else $error("missing extra cycle");
  property p_zero;
    exec && op_r == add_with_carry_op && dest_r == DEST_FILE |=> zero_r == (chk_wdata == BYTE_ZERO);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule
`default_nettype wire

// [rtl/byte_alu_pkg.sv]
// Constants, opcodes and states of the byte ALU instruction subset.
// Assumes a single core clock; shared by the datapath and its data memory.
package byte_alu_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PTR_W = 16;
  localparam int FILE_AW = 7;
  localparam int FILE_DEPTH = 128;
  localparam int PTR_LIT_W = 6;
  localparam int BIT_SEL_W = 3;
  localparam int NIB_W = 4;
  localparam int MSB_POS = 7;
  localparam int PTR_MSB_POS = 15;

  // ---------------------------------------------------------------
  // Addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [FILE_AW-1:0] INDIRECT0_ADDR = 7'h00;
  localparam logic [FILE_AW-1:0] INDIRECT1_ADDR = 7'h01;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // ---------------------------------------------------------------
  // Operations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    pointer_add_literal = 3'b000,
    and_literal_op = 3'b001,
    add_literal_op = 3'b010,
    and_register_op = 3'b011,
    add_register_op = 3'b100,
    arith_shift_right_op = 3'b101,
    add_with_carry_op = 3'b110,
    clear_bit_op = 3'b111
  } op_t;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXTRA = 2'b01,
    ST_EXEC = 2'b10
  } state_t;

endpackage

// [rtl/file_ram.sv]
// Data memory of file registers: host port and datapath port.
// Assumes one clock; read data come from a register one cycle later.
`timescale 1ns/100ps
`default_nettype none
module file_ram
  import byte_alu_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Host port
  input wire logic [FILE_AW-1:0] a_addr,
  input wire logic [DATA_W-1:0] a_wdata,
  input wire logic a_wr,
  input wire logic a_rd,
  output logic [DATA_W-1:0] a_rdata,
  // Datapath port
  input wire logic [FILE_AW-1:0] b_addr,
  input wire logic [DATA_W-1:0] b_wdata,
  input wire logic b_wr,
  input wire logic b_rd,
  output logic [DATA_W-1:0] b_rdata
);

  logic [DATA_W-1:0] mem [FILE_DEPTH];

  // ---------------------------------------------------------------
  // Writes, datapath last so it wins a clash
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (a_wr) begin
      mem[a_addr] <= a_wdata;
    end
    if (b_wr) begin
      mem[b_addr] <= b_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Registered reads
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (a_rd) begin
      a_rdata <= mem[a_addr];
    end
  end

  always_ff @(posedge core_clk) begin
    if (b_rd) begin
      b_rdata <= mem[b_addr];
    end
  end

endmodule
`default_nettype wire
